// file: sakm_pkg.sv
`default_nettype none
// ****************************************
// shared constants of the memory master
// ****************************************
package sakm_pkg;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned DEPTH      = 64;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned LEN_W      = 7;
  localparam int unsigned BLEN_W     = 13;

  // register indices on the control port
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_ARG     = 3'h1;
  localparam logic [2:0] REG_PTR     = 3'h2;
  localparam logic [2:0] REG_LEN     = 3'h3;
  localparam logic [2:0] REG_OFFSET  = 3'h4;

  // control / status bit positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_BURST = 1;
  localparam int unsigned STAT_DONE  = 1;
  localparam int unsigned STAT_IDLE  = 2;
  localparam int unsigned STAT_MISAL = 3;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [LEN_W-1:0]  RST_LEN  = 7'h00;

  // burst shaping
  localparam logic [BLEN_W-1:0] BURST_MAX  = 13'h0010;
  localparam logic [BLEN_W-1:0] BOUNDARY   = 13'h1000;
  localparam int unsigned       ALIGN_KERN = 64;
  localparam int unsigned       ALIGN_IP   = 1;
  localparam logic [1:0]        WORD_MASK  = 2'h3;
  localparam logic [2:0]        AXI_SIZE4  = 3'h2;
  localparam logic [1:0]        AXI_INCR   = 2'h1;
  localparam logic [3:0]        STRB_ALL   = 4'hf;

  typedef enum logic [1:0] {
    OFS_OFF    = 2'h0,
    OFS_DIRECT = 2'h1,
    OFS_SLAVE  = 2'h2
  } sakm_ofs_t;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_RD_SET = 9'h002,
    ST_RD_ADR = 9'h004,
    ST_RD_DAT = 9'h008,
    ST_WR_SET = 9'h010,
    ST_WR_ADR = 9'h020,
    ST_WR_FET = 9'h040,
    ST_WR_DAT = 9'h080,
    ST_WR_RSP = 9'h100
  } sakm_state_t;
endpackage
`default_nettype wire

// file: sakm_buf.sv
`default_nettype none
// ****************************************
// local word buffer, registered read
// ****************************************
module sakm_buf (
  input  wire logic                         clock_i,
  input  wire logic                         we_i,
  input  wire logic [sakm_pkg::IDX_W-1:0]   waddr_i,
  input  wire logic [sakm_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                         re_i,
  input  wire logic [sakm_pkg::IDX_W-1:0]   raddr_i,
  output var  logic [sakm_pkg::DATA_W-1:0]  q_o
);
  logic [sakm_pkg::DATA_W-1:0] mem [sakm_pkg::DEPTH];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (re_i) begin
      q_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// file: sakm_master.sv
`default_nettype none
module sakm_master #(
  parameter bit              KERNEL_CFG  = 1'b1,
  parameter int unsigned     ALIGN_BYTES = KERNEL_CFG ? sakm_pkg::ALIGN_KERN
                                                      : sakm_pkg::ALIGN_IP,
  parameter sakm_pkg::sakm_ofs_t OFFSET_MODE = KERNEL_CFG ? sakm_pkg::OFS_SLAVE
                                                          : sakm_pkg::OFS_OFF,
  parameter logic [31:0]     FIXED_BASE  = 32'h0000_0000
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_b_i,
  input  wire logic [2:0]                   reg_addr_i,
  input  wire logic [sakm_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output var  logic [sakm_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic [sakm_pkg::ADDR_W-1:0]  base_offset_i,
  output var  logic [sakm_pkg::ADDR_W-1:0]  m_araddr_o,
  output var  logic [7:0]                   m_arlen_o,
  output var  logic [2:0]                   m_arsize_o,
  output var  logic [1:0]                   m_arburst_o,
  output var  logic                         m_arvalid_o,
  input  wire logic                         m_arready_i,
  input  wire logic [sakm_pkg::DATA_W-1:0]  m_rdata_i,
  input  wire logic                         m_rlast_i,
  input  wire logic                         m_rvalid_i,
  output var  logic                         m_rready_o,
  output var  logic [sakm_pkg::ADDR_W-1:0]  m_awaddr_o,
  output var  logic [7:0]                   m_awlen_o,
  output var  logic [2:0]                   m_awsize_o,
  output var  logic [1:0]                   m_awburst_o,
  output var  logic                         m_awvalid_o,
  input  wire logic                         m_awready_i,
  output var  logic [sakm_pkg::DATA_W-1:0]  m_wdata_o,
  output var  logic [3:0]                   m_wstrb_o,
  output var  logic                         m_wlast_o,
  output var  logic                         m_wvalid_o,
  input  wire logic                         m_wready_i,
  input  wire logic                         m_bvalid_i,
  output var  logic                         m_bready_o
);
  localparam logic [31:0] ALIGN_MASK = 32'(ALIGN_BYTES - 1);

  sakm_pkg::sakm_state_t           st_r;
  logic [sakm_pkg::DATA_W-1:0]     arg_r;
  logic [sakm_pkg::ADDR_W-1:0]     ptr_r;
  logic [sakm_pkg::ADDR_W-1:0]     ofs_r;
  logic [sakm_pkg::LEN_W-1:0]      len_r;
  logic [sakm_pkg::LEN_W-1:0]      idx_r;
  logic [4:0]                      cnt_r;
  logic                            burst_en_r;
  logic                            aligned_r;
  logic                            done_r;
  logic [sakm_pkg::ADDR_W-1:0]     addr_r;
  logic [7:0]                      alen_r;
  logic [sakm_pkg::DATA_W-1:0]     wdata_r;
  logic [sakm_pkg::ADDR_W-1:0]     base_sel;
  logic [sakm_pkg::ADDR_W-1:0]     cur_addr;
  logic [sakm_pkg::ADDR_W-1:0]     start_addr;
  logic [sakm_pkg::LEN_W-1:0]      remain;
  logic [sakm_pkg::BLEN_W-1:0]     to_bnd;
  logic [sakm_pkg::BLEN_W-1:0]     blen;
  logic [sakm_pkg::DATA_W-1:0]     buf_q;
  logic                            ctrl_wr;
  logic                            start_p;
  logic                            rd_beat;
  logic                            w_beat;
  logic                            buf_re;
  logic [sakm_pkg::IDX_W-1:0]      buf_raddr;
  logic                            idle;

  // ****************************************
  // control port
  // ****************************************
  assign idle    = (st_r == sakm_pkg::ST_IDLE);
  assign ctrl_wr = reg_wr_i && (reg_addr_i == sakm_pkg::REG_CTRL);
  assign start_p = ctrl_wr && idle && reg_wdata_i[sakm_pkg::CTRL_START];

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      arg_r      <= sakm_pkg::RST_WORD;
      ptr_r      <= sakm_pkg::RST_WORD;
      ofs_r      <= sakm_pkg::RST_WORD;
      len_r      <= sakm_pkg::RST_LEN;
      burst_en_r <= 1'b0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        sakm_pkg::REG_CTRL: begin
          if (idle) begin
            burst_en_r <= reg_wdata_i[sakm_pkg::CTRL_BURST];
          end
        end
        sakm_pkg::REG_ARG:    arg_r <= reg_wdata_i;
        sakm_pkg::REG_PTR:    ptr_r <= reg_wdata_i;
        sakm_pkg::REG_LEN:    len_r <= reg_wdata_i[sakm_pkg::LEN_W-1:0];
        sakm_pkg::REG_OFFSET: ofs_r <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // done is sticky until software reads status; a new completion wins
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      done_r <= 1'b0;
    end else if (st_r == sakm_pkg::ST_WR_RSP && m_bvalid_i && idx_r == len_r) begin
      done_r <= 1'b1;
    end else if (start_p && len_r == sakm_pkg::RST_LEN) begin
      done_r <= 1'b1;
    end else if (reg_rd_i && reg_addr_i == sakm_pkg::REG_CTRL) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= sakm_pkg::RST_WORD;
    end else if (reg_rd_i) begin
      reg_rdata_o <= sakm_pkg::RST_WORD;
      case (reg_addr_i)
        sakm_pkg::REG_CTRL: begin
          reg_rdata_o[sakm_pkg::CTRL_START] <= !idle;
          reg_rdata_o[sakm_pkg::STAT_DONE]  <= done_r;
          reg_rdata_o[sakm_pkg::STAT_IDLE]  <= idle;
          reg_rdata_o[sakm_pkg::STAT_MISAL] <= !aligned_r;
        end
        sakm_pkg::REG_ARG:    reg_rdata_o <= arg_r;
        sakm_pkg::REG_PTR:    reg_rdata_o <= ptr_r;
        sakm_pkg::REG_LEN:    reg_rdata_o <= 32'(len_r);
        sakm_pkg::REG_OFFSET: reg_rdata_o <= ofs_r;
        default:              reg_rdata_o <= sakm_pkg::RST_WORD;
      endcase
    end
  end

  // ****************************************
  // address and burst shaping
  // ****************************************
  always_comb begin
    case (OFFSET_MODE)
      sakm_pkg::OFS_DIRECT: base_sel = base_offset_i;
      sakm_pkg::OFS_SLAVE:  base_sel = ofs_r;
      default:              base_sel = FIXED_BASE;
    endcase
  end

  assign start_addr = base_sel + ptr_r;
  assign cur_addr   = base_sel + ptr_r + 32'({idx_r, 2'b00});
  assign remain     = len_r - idx_r;
  assign to_bnd     = (sakm_pkg::BOUNDARY - {1'b0, cur_addr[11:0]}) >> 2;

  // a misaligned run would break boundary maths, so it drops to singles
  always_comb begin
    blen = 13'h0001;
    if (burst_en_r && aligned_r) begin
      blen = sakm_pkg::BURST_MAX;
      if (13'(remain) < blen) begin
        blen = 13'(remain);
      end
      if (to_bnd < blen) begin
        blen = to_bnd;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      aligned_r <= 1'b1;
    end else if (start_p) begin
      aligned_r <= ((start_addr & ALIGN_MASK) == 32'h0)
                   && (start_addr[1:0] == 2'h0);
    end
  end

  // ****************************************
  // transfer sequencer, shared by all ports
  // ****************************************
  assign rd_beat = (st_r == sakm_pkg::ST_RD_DAT) && m_rvalid_i;
  assign w_beat  = (st_r == sakm_pkg::ST_WR_DAT) && m_wready_i;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st_r   <= sakm_pkg::ST_IDLE;
      idx_r  <= sakm_pkg::RST_LEN;
      cnt_r  <= 5'h00;
      addr_r <= sakm_pkg::RST_WORD;
      alen_r <= 8'h00;
    end else begin
      case (st_r)
        sakm_pkg::ST_IDLE: begin
          idx_r <= sakm_pkg::RST_LEN;
          if (start_p && len_r != sakm_pkg::RST_LEN) begin
            st_r <= sakm_pkg::ST_RD_SET;
          end
        end
        sakm_pkg::ST_RD_SET, sakm_pkg::ST_WR_SET: begin
          addr_r <= cur_addr;
          alen_r <= 8'(blen - 13'h0001);
          cnt_r  <= 5'(blen);
          st_r   <= (st_r == sakm_pkg::ST_RD_SET) ? sakm_pkg::ST_RD_ADR
                                                  : sakm_pkg::ST_WR_ADR;
        end
        sakm_pkg::ST_RD_ADR: begin
          if (m_arready_i) begin
            st_r <= sakm_pkg::ST_RD_DAT;
          end
        end
        sakm_pkg::ST_RD_DAT: begin
          if (m_rvalid_i) begin
            idx_r <= idx_r + 7'h01;
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
              // read burst drained: write side takes the bus once all len words are in, else another read burst
              if (idx_r + 7'h01 == len_r) begin
                idx_r <= sakm_pkg::RST_LEN;
                st_r  <= sakm_pkg::ST_WR_SET;
              end else begin
                st_r <= sakm_pkg::ST_RD_SET;
              end
            end
          end
        end
        sakm_pkg::ST_WR_ADR: begin
          if (m_awready_i) begin
            st_r <= sakm_pkg::ST_WR_FET;
          end
        end
        sakm_pkg::ST_WR_FET: begin
          st_r <= sakm_pkg::ST_WR_DAT;
        end
        sakm_pkg::ST_WR_DAT: begin
          if (m_wready_i) begin
            idx_r <= idx_r + 7'h01;
            cnt_r <= cnt_r - 5'h01;
            st_r  <= (cnt_r == 5'h01) ? sakm_pkg::ST_WR_RSP : sakm_pkg::ST_WR_FET;
          end
        end
        sakm_pkg::ST_WR_RSP: begin
          if (m_bvalid_i) begin
            st_r <= (idx_r == len_r) ? sakm_pkg::ST_IDLE : sakm_pkg::ST_WR_SET;
          end
        end
        default: begin
          st_r <= sakm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // local buffer and write data
  // ****************************************
  // fetch one word ahead so write data leaves a flop
  assign buf_re    = (st_r == sakm_pkg::ST_WR_ADR && m_awready_i)
                     || (w_beat && cnt_r != 5'h01);
  assign buf_raddr = (st_r == sakm_pkg::ST_WR_DAT) ? 6'(idx_r + 7'h01) : 6'(idx_r);

  sakm_buf u_buf (
    .clock_i (clock_i),
    .we_i    (rd_beat),
    .waddr_i (6'(idx_r)),
    .wdata_i (m_rdata_i),
    .re_i    (buf_re),
    .raddr_i (buf_raddr),
    .q_o     (buf_q)
  );

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wdata_r <= sakm_pkg::RST_WORD;
    end else if (st_r == sakm_pkg::ST_WR_FET) begin
      wdata_r <= buf_q + arg_r;
    end
  end

  // ****************************************
  // this adapter's own bus channels
  // ****************************************
  // one read and one write stream at most; another group needs another instance
  assign m_araddr_o  = addr_r;
  assign m_arlen_o   = alen_r;
  assign m_arsize_o  = sakm_pkg::AXI_SIZE4;
  assign m_arburst_o = sakm_pkg::AXI_INCR;
  assign m_arvalid_o = (st_r == sakm_pkg::ST_RD_ADR);
  assign m_rready_o  = (st_r == sakm_pkg::ST_RD_DAT);
  assign m_awaddr_o  = addr_r;
  assign m_awlen_o   = alen_r;
  assign m_awsize_o  = sakm_pkg::AXI_SIZE4;
  assign m_awburst_o = sakm_pkg::AXI_INCR;
  assign m_awvalid_o = (st_r == sakm_pkg::ST_WR_ADR);
  assign m_wdata_o   = wdata_r;
  assign m_wstrb_o   = sakm_pkg::STRB_ALL;
  assign m_wvalid_o  = (st_r == sakm_pkg::ST_WR_DAT);
  assign m_wlast_o   = m_wvalid_o && (cnt_r == 5'h01);
  assign m_bready_o  = (st_r == sakm_pkg::ST_WR_RSP);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  logic [7:0] wbeats_r;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || (m_awvalid_o && m_awready_i)) begin
      wbeats_r <= 8'h00;
    end else if (m_wvalid_o && m_wready_i) begin
      wbeats_r <= wbeats_r + 8'h01;
    end
  end

  sequence ar_hs_s;
    m_arvalid_o && m_arready_i;
  endsequence

  sequence arg_wr_s;
    reg_wr_i && reg_addr_i == sakm_pkg::REG_ARG;
  endsequence

  burst_max_a: assert property (m_arvalid_o |-> m_arlen_o < 8'h10)
    else $error("read burst longer than 16 beats");
  no_cross_a: assert property (m_arvalid_o |->
    (13'(m_araddr_o[11:0]) + 13'({m_arlen_o, 2'b00}) + 13'h0004) <= 13'h1000)
    else $error("read burst crosses a 4 KB boundary");
  single_xfer_a: assert property ((m_arvalid_o || m_awvalid_o) && !burst_en_r
    |-> m_arlen_o == 8'h00 && m_awlen_o == 8'h00)
    else $error("burst issued with bursting off");
  misal_single_a: assert property (m_arvalid_o && !aligned_r |-> m_arlen_o == 8'h00)
    else $error("misaligned run issued a burst");
  one_addr_a: assert property (ar_hs_s |=> !m_arvalid_o [*2])
    else $error("address phase inside a burst");
  wlast_cnt_a: assert property (m_wvalid_o && m_wready_i && m_wlast_o
    |-> wbeats_r == m_awlen_o)
    else $error("last write beat does not match length");
  offset_add_a: assert property (st_r == sakm_pkg::ST_RD_SET |=>
    m_araddr_o == $past(base_sel) + $past(ptr_r) + 32'({$past(idx_r), 2'b00}))
    else $error("base offset not applied to address");
  busy_start_a: assert property (ctrl_wr && !idle |=>
    !(st_r == sakm_pkg::ST_RD_SET && idx_r == sakm_pkg::RST_LEN))
    else $error("start taken during a run");
  arg_back_a: assert property (arg_wr_s ##1 !reg_wr_i ##1 (reg_rd_i && !reg_wr_i
    && reg_addr_i == sakm_pkg::REG_ARG) |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("scalar argument does not read back");
  no_overlap_a: assert property (m_arvalid_o |-> !m_awvalid_o && !m_wvalid_o)
    else $error("read and write share the adapter at once");
endmodule
`default_nettype wire

// file: sakm_mem_model.sv
`default_nettype none
// ****************************************
// global memory behind the interconnect
// ****************************************
module sakm_mem_model (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] ar_a_i,
  input  wire logic [7:0]  ar_l_i,
  input  wire logic        ar_v_i,
  output var  logic        ar_r_o,
  output var  logic [31:0] r_d_o,
  output var  logic        r_last_o,
  output var  logic        r_v_o,
  input  wire logic        r_r_i,
  input  wire logic [31:0] aw_a_i,
  input  wire logic [7:0]  aw_l_i,
  input  wire logic        aw_v_i,
  output var  logic        aw_r_o,
  input  wire logic [31:0] w_d_i,
  input  wire logic        w_last_i,
  input  wire logic        w_v_i,
  output var  logic        w_r_o,
  output var  logic        b_v_o,
  input  wire logic        b_r_i,
  output var  int          ar_n_o,
  output var  logic [31:0] ar_last_o,
  output var  logic [7:0]  arlen_last_o,
  output var  int          bad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:1023];
  logic [31:0] ra;
  logic [31:0] wa;
  int          rleft;
  int          wleft;
  logic        tick;

  function automatic bit crosses(input logic [31:0] a, input logic [7:0] l);
    return ({20'h0, a[11:0]} + 32'(l) * 4 + 4) > 32'h1000;
  endfunction

  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      {ar_r_o, r_v_o, r_last_o, aw_r_o, w_r_o, b_v_o, tick} <= 7'h00;
      r_d_o <= 32'h5a5a_5a5a;
      rleft = 0;
      wleft = 0;
      ar_n_o <= 0;
      bad_o = 0;
    end else begin
      tick <= ~tick;
      if (ar_v_i && ar_r_o) begin
        ra = ar_a_i;
        rleft = int'(ar_l_i) + 1;
        ar_n_o <= ar_n_o + 1;
        ar_last_o <= ar_a_i;
        arlen_last_o <= ar_l_i;
        if (ar_l_i > 8'h0f || crosses(ar_a_i, ar_l_i)) bad_o = bad_o + 1;
      end
      ar_r_o <= ar_v_i && !ar_r_o && rleft == 0 && (!slow_i || tick);
      if (r_v_o && r_r_i) begin
        rleft--;
        ra += 4;
      end
      if (!(r_v_o && !r_r_i)) begin
        if (rleft > 0 && (!slow_i || tick)) begin
          r_v_o <= 1'b1;
          r_d_o <= mem[ra[11:2]]; // word addressing, same alignment as the master
          r_last_o <= (rleft == 1);
        end else begin
          // released data toggles so a stale word never passes for a match
          r_v_o <= 1'b0;
          r_last_o <= 1'b0;
          r_d_o <= ~r_d_o;
        end
      end
      if (aw_v_i && aw_r_o) begin
        wa = aw_a_i;
        wleft = int'(aw_l_i) + 1;
        if (aw_l_i > 8'h0f || crosses(aw_a_i, aw_l_i)) bad_o = bad_o + 1;
      end
      aw_r_o <= aw_v_i && !aw_r_o && wleft == 0 && !b_v_o && (!slow_i || tick);
      if (b_v_o && b_r_i) b_v_o <= 1'b0;
      if (w_v_i && w_r_o) begin
        mem[wa[11:2]] = w_d_i;
        if (w_last_i !== (wleft == 1)) bad_o = bad_o + 1;
        wleft--;
        wa += 4;
        if (wleft == 0) b_v_o <= 1'b1;
      end
      w_r_o <= w_v_i && !w_r_o && wleft > 0 && (!slow_i || tick);
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  localparam logic [31:0] OFS = 32'h1000_0000;
  localparam logic [31:0] DIR = 32'h2000_0000;
  logic [31:0] d2_araddr;
  logic        d2_arvalid;
  logic [2:0]  arsize, awsize;
  logic [1:0]  arburst, awburst;
  logic [3:0]  wstrb;
  logic        clock_i, rst_b_i, reg_wr_i, reg_rd_i, slow;
  logic [2:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, rd_val, reg_rdata_o, m_araddr_o, m_rdata_i, m_awaddr_o, m_wdata_o;
  logic [31:0] ar_last;
  logic [7:0]  m_arlen_o, m_awlen_o, arlen_last;
  logic        m_arvalid_o, m_arready_i, m_rlast_i, m_rvalid_i, m_rready_o, m_awvalid_o;
  logic        m_awready_i, m_wlast_o, m_wvalid_o, m_wready_i, m_bvalid_i, m_bready_o;
  int          ar_n, bad, err_count, n_tests;
  logic [31:0] snap [0:1023];

  sakm_master #(.KERNEL_CFG(1'b1)) dut_u (.clock_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .base_offset_i(32'h0000_0000), .m_araddr_o,
    .m_arlen_o, .m_arsize_o(arsize), .m_arburst_o(arburst), .m_arvalid_o, .m_arready_i,
    .m_rdata_i, .m_rlast_i, .m_rvalid_i, .m_rready_o, .m_awaddr_o, .m_awlen_o,
    .m_awsize_o(awsize), .m_awburst_o(awburst), .m_awvalid_o, .m_awready_i, .m_wdata_o,
    .m_wstrb_o(wstrb), .m_wlast_o, .m_wvalid_o, .m_wready_i, .m_bvalid_i, .m_bready_o);

  // direct offset mode; its read address is never granted, so it parks on its first one
  sakm_master #(.KERNEL_CFG(1'b0), .OFFSET_MODE(sakm_pkg::OFS_DIRECT)) dut_dir_u (.clock_i,
    .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(),
    .base_offset_i(DIR), .m_araddr_o(d2_araddr), .m_arlen_o(), .m_arsize_o(), .m_arburst_o(),
    .m_arvalid_o(d2_arvalid), .m_arready_i(1'b0), .m_rdata_i(32'h0), .m_rlast_i(1'b0),
    .m_rvalid_i(1'b0), .m_rready_o(), .m_awaddr_o(), .m_awlen_o(), .m_awsize_o(),
    .m_awburst_o(), .m_awvalid_o(), .m_awready_i(1'b0), .m_wdata_o(), .m_wstrb_o(),
    .m_wlast_o(), .m_wvalid_o(), .m_wready_i(1'b0), .m_bvalid_i(1'b0), .m_bready_o());

  sakm_mem_model mem_u (.clock_i, .rst_b_i, .slow_i(slow), .ar_a_i(m_araddr_o),
    .ar_l_i(m_arlen_o), .ar_v_i(m_arvalid_o), .ar_r_o(m_arready_i), .r_d_o(m_rdata_i),
    .r_last_o(m_rlast_i), .r_v_o(m_rvalid_i), .r_r_i(m_rready_o), .aw_a_i(m_awaddr_o),
    .aw_l_i(m_awlen_o), .aw_v_i(m_awvalid_o), .aw_r_o(m_awready_i), .w_d_i(m_wdata_o),
    .w_last_i(m_wlast_o), .w_v_i(m_wvalid_o), .w_r_o(m_wready_i), .b_v_o(m_bvalid_i),
    .b_r_i(m_bready_o), .ar_n_o(ar_n), .ar_last_o(ar_last), .arlen_last_o(arlen_last),
    .bad_o(bad));

  // ****************************************
  // register port cycles
  // ****************************************
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic check_reset;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a));
      `CHK(rd_val, (a == 0) ? (32'h1 << sakm_pkg::STAT_IDLE) : 32'h0)
    end
    `CHK({arsize, awsize, arburst, awburst, wstrb}, {3'h2, 3'h2, 2'h1, 2'h1, 4'hf})
  endtask

  task automatic check_regs;
    logic [2:0]  ad [5] = '{3'h1, 3'h4, 3'h2, 3'h3, 3'h6};
    logic [31:0] wv [5] = '{32'hdead_beef, OFS, 32'h0000_0fc4, 32'h0000_0085, 32'hffff_ffff};
    logic [31:0] ev [5] = '{32'hdead_beef, OFS, 32'h0000_0fc4, 32'h0000_0005, 32'h0};
    for (int k = 0; k < 5; k++) wr(ad[k], wv[k]);
    for (int k = 0; k < 5; k++) begin
      rd(ad[k]);
      `CHK(rd_val, ev[k])
    end
    wr(sakm_pkg::REG_ARG, 32'h0bad_cafe);
    rd(sakm_pkg::REG_ARG);
    `CHK(rd_val, 32'h0bad_cafe)
  endtask

  // len words at OFS+ptr read, arg added, written back; nar address phases expected
  task automatic run(input logic [31:0] ptr, input int len, input logic [31:0] arg,
                     input bit bst, input bit sl, input int nar, input int lastb, input bit mis);
    int a0;
    int i;
    logic [9:0] ix;
    snap = mem_u.mem;
    slow <= sl;
    wr(sakm_pkg::REG_PTR, ptr);
    wr(sakm_pkg::REG_LEN, 32'(len));
    wr(sakm_pkg::REG_ARG, arg);
    a0 = ar_n;
    wr(sakm_pkg::REG_CTRL, {30'h0, bst, 1'b1});
    if (len != 0) begin
      rd(sakm_pkg::REG_CTRL);
      `CHK(rd_val[0], 1'b1)
      // a second start while busy must not launch another run
      wr(sakm_pkg::REG_CTRL, {30'h0, bst, 1'b1});
    end
    i = 0;
    do begin
      rd(sakm_pkg::REG_CTRL);
      i++;
    end while (rd_val[sakm_pkg::STAT_DONE] !== 1'b1 && i < 400);
    if (i >= 400) begin
      err_count++;
      print_verdict();
    end
    `CHK(rd_val[sakm_pkg::STAT_MISAL], mis)
    repeat (60) @(posedge clock_i);
    rd(sakm_pkg::REG_CTRL);
    `CHK(rd_val[3:1], {mis, 2'b10})
    `CHK(ar_n - a0, nar)
    if (nar > 0) begin
      `CHK(ar_last, OFS + ptr + 32'(4 * (len - lastb)))
      `CHK(arlen_last, 8'(lastb - 1))
    end
    `CHK(bad, 0)
    for (i = 0; i <= len; i++) begin
      ix = 10'((ptr >> 2) + 32'(i));
      `CHK(mem_u.mem[ix], (i < len) ? snap[ix] + arg : snap[ix])
    end
  endtask

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    err_count++;
    print_verdict();
  end

  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, slow} = 4'h0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 32'h0;
    err_count = 0;
    n_tests = 0;
    for (int k = 0; k < 1024; k++) mem_u.mem[k] = 32'h0a00_0000 + 32'(k * 7);
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    check_reset();
    check_regs();
    run(32'h0000_0040, 20, 32'h0000_0011, 1'b1, 1'b0, 2, 4, 1'b0);
    `CHK(d2_arvalid, 1'b1)
    `CHK(d2_araddr, DIR + 32'h0000_0040)
    run(32'h0000_0100, 20, 32'h0000_0022, 1'b1, 1'b1, 2, 4, 1'b0);
    run(32'h0000_0204, 3, 32'h0000_0033, 1'b1, 1'b0, 3, 1, 1'b1);
    run(32'h0000_0300, 3, 32'h0000_0044, 1'b0, 1'b0, 3, 1, 1'b0);
    run(32'h0000_0fc0, 17, 32'h0000_0055, 1'b1, 1'b0, 2, 1, 1'b0);
    run(32'h0000_0400, 0, 32'h0000_0066, 1'b1, 1'b0, 0, 1, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
